// ==== logic/drseq_pkg.sv ====
// Package: constants and types of the data retention sequencer
package drseq_pkg;
    // Register byte offsets
    localparam logic [11:0] DRSEQ_OFF_CTRL = 12'h000;
    localparam logic [11:0] DRSEQ_OFF_STAT = 12'h004;
    localparam logic [11:0] DRSEQ_OFF_IRQ = 12'h008;
    localparam logic [11:0] DRSEQ_OFF_MASK = 12'h00c;
    localparam logic [11:0] DRSEQ_OFF_ERR = 12'h010;
    // Control register fields (write one pulses, except ONLINE which is a held level)
    localparam int DRSEQ_CTRL_ARRAY_WR = 0;
    localparam int DRSEQ_CTRL_ONLINE_OK = 1;
    localparam int DRSEQ_CTRL_TEST_FAIL = 2;
    localparam int DRSEQ_CTRL_ONLINE = 3;
    // Interrupt bit positions
    localparam int DRSEQ_IRQ_SAVE_DONE = 0;
    localparam int DRSEQ_IRQ_RESTORE_DONE = 1;
    localparam int DRSEQ_IRQ_ABORT = 2;
    localparam int DRSEQ_IRQ_FAULT = 3;
    localparam int DRSEQ_IRQ_W = 4;
    localparam logic [3:0] DRSEQ_MASK_RST = 4'h0;
    // Error codes reported at power-up
    localparam logic [7:0] DRSEQ_ERR_NONE = 8'h00;
    localparam logic [7:0] DRSEQ_ERR_E0 = 8'he0;
    localparam logic [7:0] DRSEQ_ERR_E1 = 8'he1;
    localparam int DRSEQ_FAULT_REPORTS = 3;
    // Timing
    localparam longint DRSEQ_CLK_HZ = 100_000_000;
    localparam longint DRSEQ_SELFTEST_S = 30;
    localparam longint DRSEQ_RESTORE_MIN_S = 120;
    localparam longint DRSEQ_RESTORE_MAX_S = 480;
    localparam longint DRSEQ_SELFTEST_CYC = DRSEQ_SELFTEST_S * DRSEQ_CLK_HZ;
    localparam longint DRSEQ_BIT_CELL_NS = 50;
    localparam int DRSEQ_BIT_CELL_CYC = int'((DRSEQ_BIT_CELL_NS * 1000
        + 1000 * 1_000_000_000 / DRSEQ_CLK_HZ - 1)
        / (1000 * 1_000_000_000 / DRSEQ_CLK_HZ));
    // Backup status encodings
    typedef enum logic [1:0] {
        DRSEQ_BK_NODATA = 2'h0,
        DRSEQ_BK_INVALID = 2'h1,
        DRSEQ_BK_VALID = 2'h2
    } drseq_bk_t;
    // Requests from the power and spindle side
    typedef struct packed {
        logic ac_lost;
        logic ac_back;
        logic spin_up;
        logic spin_down;
    } drseq_evt_t;
    // Progress of the backup drive engine
    typedef struct packed {
        logic save_done;
        logic restore_done;
        logic fail;
    } drseq_eng_t;
endpackage

// ==== logic/drseq_top.sv ====
// Data retention sequencer with APB register slave
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
// Functional notes
// - AC loss aborts restore, save continues
// - AC loss while idle starts save
// - AC return stops save, maybe restores
// - Spin-down saves if array valid, backup not
// - Spin-up aborts save, status no-data
// - Spin-down save marks backup status invalid
// - Ignore spin requests until restore complete
// - Report errors through attention output
// - Fault reported three times when online
// - Fault persists until next power-up
// - Self test runs before power-up reload
// - Power-up restore waits on engine completion
// - Link bit cell is 50 ns
// - Backup status valid, invalid, no-data updates
// - Power-up E0 or E1 with array zeroing
module drseq_top #(
    parameter longint SELFTEST_CYC = drseq_pkg::DRSEQ_SELFTEST_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire drseq_pkg::drseq_evt_t evt,
    input wire drseq_pkg::drseq_eng_t eng,
    input wire logic array_valid,
    input wire drseq_pkg::drseq_bk_t bk_stored,
    output logic save_start,
    output logic save_stop,
    output logic restore_start,
    output logic restore_stop,
    output logic zero_start,
    output drseq_pkg::drseq_bk_t bk_status,
    output logic attention,
    output logic faulted,
    output logic link_bit_tick,
    output logic irq
);
    import drseq_pkg::*;

    typedef enum logic [2:0] {
        ST_SELFTEST,
        ST_RESTORE,
        ST_IDLE,
        ST_SAVE,
        ST_ZERO
    } drseq_st_t;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    // ------------------------------------------------------------
    // APB access decode
    // ------------------------------------------------------------
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    assign pready = 1'b1;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign mapped = hit(paddr, DRSEQ_OFF_CTRL) | hit(paddr, DRSEQ_OFF_STAT)
        | hit(paddr, DRSEQ_OFF_IRQ) | hit(paddr, DRSEQ_OFF_MASK)
        | hit(paddr, DRSEQ_OFF_ERR);
    assign pslverr = psel & penable & ~mapped;

    logic ctl_wr;
    logic arr_wr;
    logic online_ok;
    logic test_fail;
    assign ctl_wr = wr_acc & hit(paddr, DRSEQ_OFF_CTRL);
    assign arr_wr = ctl_wr & pwdata[DRSEQ_CTRL_ARRAY_WR];
    assign online_ok = ctl_wr & pwdata[DRSEQ_CTRL_ONLINE_OK];
    assign test_fail = ctl_wr & pwdata[DRSEQ_CTRL_TEST_FAIL];

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    drseq_st_t st_r, st_nxt;
    drseq_bk_t bk_r, bk_nxt;
    logic restored_r, restored_nxt;
    logic fault_r, fault_nxt;
    logic online_r, online_nxt;
    logic [1:0] rep_r, rep_nxt;
    logic [7:0] err_r, err_nxt;
    logic [63:0] cnt_r, cnt_nxt;
    logic [3:0] pulse_r, pulse_nxt;
    logic [3:0] ev_set;
    logic ac_r, ac_nxt;

    always_comb
    begin
        st_nxt = st_r;
        bk_nxt = bk_r;
        restored_nxt = restored_r;
        fault_nxt = fault_r;
        online_nxt = online_r;
        rep_nxt = rep_r;
        err_nxt = err_r;
        cnt_nxt = cnt_r;
        pulse_nxt = 4'h0;
        ev_set = 4'h0;
        ac_nxt = ac_r;
        if (evt.ac_lost)
            ac_nxt = 1'b0;
        if (evt.ac_back)
            ac_nxt = 1'b1;
        if (ctl_wr)
            online_nxt = pwdata[DRSEQ_CTRL_ONLINE];
        if (arr_wr && bk_r == DRSEQ_BK_VALID)
            bk_nxt = DRSEQ_BK_INVALID;
        if (online_ok && bk_r == DRSEQ_BK_VALID)
            bk_nxt = DRSEQ_BK_INVALID;
        case (st_r)
            ST_SELFTEST:
            begin
                cnt_nxt = cnt_r + 64'h1;
                if (cnt_r >= 64'(SELFTEST_CYC) - 64'h1)
                begin
                    cnt_nxt = 64'h0;
                    if (bk_stored == DRSEQ_BK_VALID)
                    begin
                        st_nxt = ST_RESTORE;
                        pulse_nxt[1] = 1'b1;
                    end
                    else
                    begin
                        st_nxt = ST_ZERO;
                        pulse_nxt[3] = 1'b1;
                        err_nxt = (bk_stored == DRSEQ_BK_NODATA) ?
                            DRSEQ_ERR_E0 : DRSEQ_ERR_E1;
                        ev_set[DRSEQ_IRQ_FAULT] = 1'b1;
                    end
                    bk_nxt = bk_stored;
                end
            end
            ST_RESTORE:
            begin
                if (evt.ac_lost)
                begin
                    st_nxt = ST_IDLE;
                    pulse_nxt[2] = 1'b1;
                    ev_set[DRSEQ_IRQ_ABORT] = 1'b1;
                end
                else if (eng.restore_done)
                begin
                    st_nxt = ST_IDLE;
                    restored_nxt = 1'b1;
                    ev_set[DRSEQ_IRQ_RESTORE_DONE] = 1'b1;
                end
            end
            ST_ZERO:
                if (eng.restore_done)
                begin
                    st_nxt = ST_IDLE;
                    restored_nxt = 1'b1;
                end
            ST_IDLE:
            begin
                if (evt.ac_lost && !fault_r)
                begin
                    st_nxt = ST_SAVE;
                    pulse_nxt[0] = 1'b1;
                end
                else if (evt.ac_back && !restored_r && !fault_r)
                begin
                    st_nxt = ST_RESTORE;
                    pulse_nxt[1] = 1'b1;
                end
                else if (evt.spin_down && restored_r && !fault_r
                    && array_valid && bk_r != DRSEQ_BK_VALID)
                begin
                    st_nxt = ST_SAVE;
                    pulse_nxt[0] = 1'b1;
                    bk_nxt = DRSEQ_BK_INVALID;
                end
            end
            ST_SAVE:
            begin
                if (evt.ac_back || (evt.spin_up && restored_r))
                begin
                    st_nxt = ST_IDLE;
                    pulse_nxt[0] = 1'b0;
                    ev_set[DRSEQ_IRQ_ABORT] = 1'b1;
                    bk_nxt = DRSEQ_BK_NODATA;
                end
                else if (eng.save_done)
                begin
                    st_nxt = ST_IDLE;
                    bk_nxt = DRSEQ_BK_VALID;
                    ev_set[DRSEQ_IRQ_SAVE_DONE] = 1'b1;
                end
            end
            default:
                st_nxt = ST_SELFTEST;
        endcase
        if (st_nxt == ST_IDLE && st_r == ST_SAVE && !eng.save_done)
            pulse_nxt[0] = 1'b0;
        if ((test_fail || eng.fail) && !fault_r)
        begin
            fault_nxt = 1'b1;
            rep_nxt = 2'(DRSEQ_FAULT_REPORTS);
            ev_set[DRSEQ_IRQ_FAULT] = 1'b1;
            if (st_r == ST_SAVE)
                bk_nxt = DRSEQ_BK_NODATA;
            if (st_r == ST_SAVE || st_r == ST_RESTORE)
                st_nxt = ST_IDLE;
        end
        else if (rep_r != 2'h0 && online_r && rd_acc
            && hit(paddr, DRSEQ_OFF_ERR))
            rep_nxt = rep_r - 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= ST_SELFTEST;
            bk_r <= DRSEQ_BK_NODATA;
            restored_r <= 1'b0;
            fault_r <= 1'b0;
            online_r <= 1'b0;
            rep_r <= 2'h0;
            err_r <= DRSEQ_ERR_NONE;
            cnt_r <= 64'h0;
            pulse_r <= 4'h0;
            ac_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            bk_r <= bk_nxt;
            restored_r <= restored_nxt;
            fault_r <= fault_nxt;
            online_r <= online_nxt;
            rep_r <= rep_nxt;
            err_r <= err_nxt;
            cnt_r <= cnt_nxt;
            pulse_r <= pulse_nxt;
            ac_r <= ac_nxt;
        end
    end

    // Abort strobes follow the leaving edge of the active state
    logic save_stop_r, save_stop_nxt;
    logic rest_stop_r, rest_stop_nxt;
    assign save_stop_nxt = (st_r == ST_SAVE) && (st_nxt == ST_IDLE)
        && !eng.save_done;
    assign rest_stop_nxt = (st_r == ST_RESTORE) && (st_nxt == ST_IDLE)
        && !eng.restore_done;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            save_stop_r <= 1'b0;
            rest_stop_r <= 1'b0;
        end
        else
        begin
            save_stop_r <= save_stop_nxt;
            rest_stop_r <= rest_stop_nxt;
        end
    end

    assign save_start = pulse_r[0];
    assign restore_start = pulse_r[1];
    assign save_stop = save_stop_r;
    assign restore_stop = rest_stop_r;
    assign zero_start = pulse_r[3];
    assign bk_status = bk_r;
    assign faulted = fault_r;
    assign attention = online_r & (rep_r != 2'h0 || err_r != 8'h00);

    // ------------------------------------------------------------
    // Link bit cell timer
    // ------------------------------------------------------------
    logic [7:0] bit_r, bit_nxt;
    logic tick_r, tick_nxt;
    always_comb
    begin
        tick_nxt = (bit_r == 8'(DRSEQ_BIT_CELL_CYC - 1));
        bit_nxt = tick_nxt ? 8'h0 : bit_r + 8'h1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_r <= 8'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            bit_r <= bit_nxt;
            tick_r <= tick_nxt;
        end
    end
    assign link_bit_tick = tick_r;

    // ------------------------------------------------------------
    // Interrupt status, mask and read data
    // ------------------------------------------------------------
    logic [3:0] irq_r, irq_nxt;
    logic [3:0] mask_r, mask_nxt;
    logic [31:0] rd_nxt;
    logic [31:0] prdata_r;
    always_comb
    begin
        irq_nxt = irq_r;
        mask_nxt = mask_r;
        if (wr_acc && hit(paddr, DRSEQ_OFF_IRQ))
            irq_nxt = irq_r & ~pwdata[3:0];
        irq_nxt = irq_nxt | ev_set;
        if (wr_acc && hit(paddr, DRSEQ_OFF_MASK))
            mask_nxt = pwdata[3:0];
        rd_nxt = 32'h0;
        if (psel && !penable && !pwrite)
        begin
            if (hit(paddr, DRSEQ_OFF_CTRL))
                rd_nxt = {28'h0, online_r, 3'h0};
            else if (hit(paddr, DRSEQ_OFF_STAT))
                rd_nxt = {20'h0, rep_r, fault_r, restored_r,
                    1'b0, st_r, 1'b0, bk_r, 1'b0};
            else if (hit(paddr, DRSEQ_OFF_IRQ))
                rd_nxt = {28'h0, irq_r};
            else if (hit(paddr, DRSEQ_OFF_MASK))
                rd_nxt = {28'h0, mask_r};
            else if (hit(paddr, DRSEQ_OFF_ERR))
                rd_nxt = {24'h0, err_r};
        end
        else
            rd_nxt = prdata_r;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_r <= 4'h0;
            mask_r <= DRSEQ_MASK_RST;
            prdata_r <= 32'h0;
        end
        else
        begin
            irq_r <= irq_nxt;
            mask_r <= mask_nxt;
            prdata_r <= rd_nxt;
        end
    end
    assign prdata = prdata_r;
    assign irq = |(irq_r & mask_r);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_restore_abort: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == ST_RESTORE && evt.ac_lost && !eng.restore_done
        |=> st_r == ST_IDLE && restore_stop)
        else $error("restore not aborted on ac loss");
    a_idle_save: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == ST_IDLE && evt.ac_lost && !fault_r && !test_fail && !eng.fail
        |=> st_r == ST_SAVE && save_start)
        else $error("save not started on ac loss");
    a_ac_back_stop: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == ST_SAVE && evt.ac_back |=> st_r == ST_IDLE && bk_r == DRSEQ_BK_NODATA)
        else $error("save not stopped on ac return");
    a_spin_down_gate: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == ST_IDLE && !evt.ac_lost && !evt.ac_back && !array_valid
        |=> st_r != ST_SAVE)
        else $error("save started with invalid array");
    a_spin_up_abort: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == ST_SAVE && evt.spin_up && restored_r && !eng.save_done
        |=> bk_r == DRSEQ_BK_NODATA && save_stop)
        else $error("spin up did not abort save");
    a_spin_save_inv: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == ST_IDLE && $past(st_r) == ST_IDLE && evt.spin_down && restored_r
        && !evt.ac_lost && !evt.ac_back && !fault_r && array_valid
        && bk_r != DRSEQ_BK_VALID && !test_fail && !eng.fail
        |=> bk_r == DRSEQ_BK_INVALID)
        else $error("spin down save left status");
    a_spin_before_rst: assert property (@(posedge pclk) disable iff (!presetn)
        !restored_r && !evt.ac_lost && st_r == ST_IDLE |=> st_r != ST_SAVE)
        else $error("spin acted before restore");
    a_fault_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        fault_r |=> fault_r)
        else $error("fault cleared without power-up");
    a_fault_count: assert property (@(posedge pclk) disable iff (!presetn)
        !fault_r && test_fail |=> rep_r == 2'd3 && fault_r)
        else $error("fault report count wrong");
endmodule // drseq_top

// ==== sim/drseq_eng_model.sv ====
// Behavioural backup drive engine facing the sequencer
`timescale 1ns/1ns
module drseq_eng_model #(
    parameter int SAVE_CYC = 30,
    parameter int LOAD_CYC = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic save_start,
    input wire logic save_stop,
    input wire logic restore_start,
    input wire logic restore_stop,
    input wire logic zero_start,
    output drseq_pkg::drseq_eng_t eng
);
    import drseq_pkg::*;
    logic [1:0] mode_r;
    int cnt_r;
    // ----------------------------------------
    // Transfer timing
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= 2'h0;
            cnt_r <= 0;
            eng <= '0;
        end
        else
        begin
            eng <= '0;
            if (save_stop || restore_stop)
                mode_r <= 2'h0;
            else if (save_start)
            begin
                mode_r <= 2'h1;
                cnt_r <= SAVE_CYC;
            end
            else if (restore_start || zero_start)
            begin
                mode_r <= 2'h2;
                cnt_r <= LOAD_CYC;
            end
            else if (mode_r != 2'h0)
            begin
                if (cnt_r == 0)
                begin
                    mode_r <= 2'h0;
                    eng.save_done <= (mode_r == 2'h1);
                    eng.restore_done <= (mode_r == 2'h2);
                end
                else
                    cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule // drseq_eng_model

// ==== sim/tb.sv ====
// Self-checking bench of the data retention sequencer
`timescale 1ns/1ns
module tb;
    import drseq_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, last_err, array_valid = 0, s;
    drseq_evt_t evt = '0;
    drseq_eng_t eng;
    drseq_bk_t bk_stored = DRSEQ_BK_VALID, bk_status;
    logic save_start, save_stop, restore_start, restore_stop, zero_start;
    logic attention, faulted, link_bit_tick, irq;
    logic [4:0] strb;
    int n_mismatch = 0, n_checks = 0;
    assign strb = {zero_start, restore_stop, restore_start, save_stop,
        save_start};
    drseq_top #(.SELFTEST_CYC(20)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .eng(eng),
        .array_valid(array_valid), .bk_stored(bk_stored),
        .save_start(save_start), .save_stop(save_stop),
        .restore_start(restore_start), .restore_stop(restore_stop),
        .zero_start(zero_start), .bk_status(bk_status),
        .attention(attention), .faulted(faulted),
        .link_bit_tick(link_bit_tick), .irq(irq));
    drseq_eng_model eng_m (.pclk(pclk), .presetn(presetn),
        .save_start(save_start), .save_stop(save_stop),
        .restore_start(restore_start), .restore_stop(restore_stop),
        .zero_start(zero_start), .eng(eng));
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            n_mismatch++;
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic do_reset(input drseq_bk_t b);
        presetn <= 1'b0;
        bk_stored <= b;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic pulse(input logic [3:0] v);
        evt <= drseq_evt_t'(v);
        @(posedge pclk);
        evt <= '0;
    endtask
    task automatic seen_in(input int idx, input int n);
        s = 1'b0;
        repeat (n)
        begin
            @(posedge pclk);
            if (strb[idx] === 1'b1)
                s = 1'b1;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_zero();
        array_valid <= 1'b1;
        do_reset(DRSEQ_BK_NODATA);
        seen_in(4, 30);
        chk(s, 1);
        apb(0, DRSEQ_OFF_ERR, 0);
        chk(q, DRSEQ_ERR_E0);
        pulse(4'h1);
        seen_in(0, 6);
        chk(s, 0);
        do_reset(DRSEQ_BK_INVALID);
        seen_in(4, 30);
        apb(0, DRSEQ_OFF_ERR, 0);
        chk(q, DRSEQ_ERR_E1);
        $display("t_zero done");
    endtask
    task automatic t_restore_abort();
        do_reset(DRSEQ_BK_VALID);
        seen_in(2, 30);
        pulse(4'h8);
        seen_in(3, 6);
        chk(s, 1);
        $display("t_restore_abort done");
    endtask
    task automatic t_powerup();
        do_reset(DRSEQ_BK_VALID);
        seen_in(2, 18);
        chk(s, 0);
        seen_in(2, 14);
        chk(s, 1);
        repeat (60) @(posedge pclk);
        apb(0, DRSEQ_OFF_IRQ, 0);
        chk(q[DRSEQ_IRQ_RESTORE_DONE], 1);
        apb(0, DRSEQ_OFF_ERR, 0);
        chk(q, DRSEQ_ERR_NONE);
        apb(0, 12'h020, 0);
        chk({last_err, q}, {1'b1, 32'h0});
        $display("t_powerup done");
    endtask
    task automatic t_ac_save();
        pulse(4'h8);
        seen_in(0, 6);
        chk(s, 1);
        repeat (40) @(posedge pclk);
        chk(bk_status, DRSEQ_BK_VALID);
        apb(0, DRSEQ_OFF_IRQ, 0);
        chk(q[DRSEQ_IRQ_SAVE_DONE], 1);
        chk(irq, 0);
        apb(1, DRSEQ_OFF_MASK, 32'h1);
        chk(irq, 1);
        apb(1, DRSEQ_OFF_IRQ, 32'hf);
        chk(irq, 0);
        pulse(4'h1);
        seen_in(0, 6);
        chk(s, 0);
        $display("t_ac_save done");
    endtask
    task automatic t_spin();
        apb(1, DRSEQ_OFF_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        chk(bk_status, DRSEQ_BK_INVALID);
        pulse(4'h1);
        seen_in(0, 6);
        chk(s, 1);
        chk(bk_status, DRSEQ_BK_INVALID);
        pulse(4'h2);
        seen_in(1, 6);
        chk(s, 1);
        chk(bk_status, DRSEQ_BK_NODATA);
        array_valid <= 1'b0;
        pulse(4'h1);
        seen_in(0, 6);
        chk(s, 0);
        array_valid <= 1'b1;
        $display("t_spin done");
    endtask
    task automatic t_ac_back();
        pulse(4'h8);
        seen_in(0, 6);
        pulse(4'h8);
        seen_in(1, 6);
        chk(s, 0);
        pulse(4'h4);
        seen_in(1, 6);
        chk(s, 1);
        pulse(4'h4);
        seen_in(2, 6);
        chk(s, 0);
        $display("t_ac_back done");
    endtask
    task automatic t_tick();
        int c;
        c = 0;
        seen_in(0, 1);
        while (link_bit_tick !== 1'b1 && c < 10)
        begin
            @(posedge pclk);
            c++;
        end
        c = 0;
        do
        begin
            @(posedge pclk);
            c++;
        end
        while (link_bit_tick !== 1'b1 && c < 10);
        chk(c, 50 / 10);
        $display("t_tick done");
    endtask
    task automatic t_fault();
        apb(1, DRSEQ_OFF_CTRL, 32'h8);
        chk(attention, 0);
        apb(1, DRSEQ_OFF_CTRL, 32'hc);
        repeat (2) @(posedge pclk);
        chk({faulted, attention}, 2'h3);
        apb(0, DRSEQ_OFF_IRQ, 0);
        chk(q[DRSEQ_IRQ_FAULT], 1);
        repeat (3) apb(0, DRSEQ_OFF_ERR, 0);
        chk({faulted, attention}, 2'h2);
        pulse(4'h8);
        seen_in(0, 6);
        chk(s, 0);
        $display("t_fault done");
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        do_reset(DRSEQ_BK_VALID);
        t_zero();
        t_restore_abort();
        t_powerup();
        t_ac_save();
        t_spin();
        t_ac_back();
        t_tick();
        t_fault();
        end_sim();
    end
    initial
    begin
        #20000;
        n_mismatch++;
        end_sim();
    end
endmodule // tb
